// >>> rtl/scsif_pkg.sv
// constants, field layouts and state types of the smart-card serial channel
package scsif_pkg;
  // apb byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_TXD  = 8'h0c;
  localparam logic [7:0] ADDR_RXD  = 8'h10;
  localparam logic [7:0] ADDR_RATE = 8'h14;
  // reset values
  localparam logic [7:0] RATE_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  // basic-clock ticks per bit and in-bit positions
  localparam int unsigned ETU_TICKS = 372;
  localparam logic [8:0] ETU_LAST  = 9'(ETU_TICKS - 1);
  localparam logic [8:0] SAMPLE_AT = 9'h0b9;  // 186th pulse, counted from 0
  // bit indices in a frame: start=0, data=1..8, parity=9
  localparam logic [3:0] PAR_BIT    = 4'h9;
  localparam logic [3:0] SLOT_BIT   = 4'ha;
  localparam logic [3:0] TX_CHK_BIT = 4'hb;
  localparam logic [3:0] TX_END_BIT = 4'hc;
  localparam logic [3:0] RX_END_BIT = 4'hb;
  // control register layout, bit 0 is tx_irq_enable
  typedef struct packed {
    logic clk_oe;    // clock_output_enable
    logic idle_lvl;  // clock_idle_level_bit
    logic rx_en;     // rx_enable_bit
    logic tx_en;     // tx_enable_bit
    logic rx_irq_enable;       // rx_irq_enable
    logic tx_irq_enable;       // tx_irq_enable
  } scsif_ctrl_t;
  // mode register layout, bit 0 is fixed_clock_mode
  typedef struct packed {
    logic card_en;
    logic odd;
    logic fixed_clk;
  } scsif_mode_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_FRAME = 2'b10} scsif_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_FRAME = 2'b10} scsif_rx_st_t;
endpackage

// >>> rtl/scsif_core.sv
// smart-card mode serial channel: apb registers, transfer-controller strobes, card line
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scsif_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dma_tx_write,
  input  wire logic [7:0]  dma_tx_data,
  input  wire logic        dma_rx_read,
  output logic      [7:0]  dma_rx_data,
  output logic             tx_ready_irq,
  output logic             rx_ready_irq,
  output logic             error_irq,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe,
  output logic             sck_out,
  output logic             sck_oe
);
  scsif_pkg::scsif_ctrl_t  ctrl;
  scsif_pkg::scsif_mode_t  mode;
  scsif_pkg::scsif_tx_st_t tx_st;
  scsif_pkg::scsif_rx_st_t rx_st;
  logic [7:0] rate, tx_data, rx_data, rx_shift, half_cnt;
  logic       tx_buffer_empty, tx_done_flag, rx_buffer_full;
  logic       overrun_flag, parity_error_flag, error_signal_flag;
  logic       phase, clk_run, clk_idle;
  logic [8:0] tx_cnt, rx_cnt;
  logic [3:0] tx_bit, rx_bit;
  logic       tx_err_seen, rx_perr;
  logic [2:0] line_sync;

  // even parity, or odd when selected
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction
  // apb decode; no wait states, unmapped offsets answer pslverr
  wire setup    = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite;
  wire hit_mode = (paddr == scsif_pkg::ADDR_MODE);
  wire hit_ctrl = (paddr == scsif_pkg::ADDR_CTRL);
  wire hit_stat = (paddr == scsif_pkg::ADDR_STAT);
  wire hit_txd  = (paddr == scsif_pkg::ADDR_TXD);
  wire hit_rxd  = (paddr == scsif_pkg::ADDR_RXD);
  wire hit_rate = (paddr == scsif_pkg::ADDR_RATE);
  wire mapped   = hit_mode | hit_ctrl | hit_stat | hit_txd | hit_rxd | hit_rate;
  wire stat_wr  = wr_acc & hit_stat;
  wire [5:0] stat_rd = {error_signal_flag, parity_error_flag, overrun_flag,
                        rx_buffer_full, tx_done_flag, tx_buffer_empty};
  wire [31:0] rd_mux = hit_mode ? {29'h0, mode} :
                       hit_ctrl ? {26'h0, ctrl} :
                       hit_stat ? {26'h0, stat_rd} :
                       hit_txd  ? {24'h0, tx_data} :
                       hit_rxd  ? {24'h0, rx_data} :
                       hit_rate ? {24'h0, rate} : 32'h0;
  // a tx data write from software or the transfer controller
  wire tx_load  = dma_tx_write | (wr_acc & hit_txd);
  wire [7:0] tx_wdata = dma_tx_write ? dma_tx_data : pwdata[7:0];

  // data answer is latched in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= rd_mux;
        pslverr <= ~mapped;
      end
    end
  end

  // software-written configuration, plus the tx data register that the transfer controller also loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= '0;
      mode    <= '0;
      rate    <= scsif_pkg::RATE_RST;
      tx_data <= scsif_pkg::DATA_RST;
    end else begin
      if (wr_acc & hit_ctrl) ctrl <= pwdata[5:0];
      if (wr_acc & hit_mode) mode <= pwdata[2:0];
      if (wr_acc & hit_rate) rate <= pwdata[7:0];
      if (tx_load) tx_data <= tx_wdata;
    end
  end

  // basic clock: one period is 2*(rate+1) pclk cycles, tick at its rising half
  wire half_wrap  = (half_cnt == rate);
  wire basic_tick = half_wrap & ~phase;
  // fixed clock mode only changes run/level at a period start, so no runt pulse
  wire run_now    = mode.fixed_clk ? clk_run : ctrl.clk_oe;
  wire idle_now   = mode.fixed_clk ? clk_idle : ctrl.idle_lvl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= 8'h00;
      phase    <= 1'b0;
      clk_run  <= 1'b0;
      clk_idle <= 1'b0;
    end else begin
      half_cnt <= half_wrap ? 8'h00 : half_cnt + 8'h01;
      if (half_wrap) phase <= ~phase;
      if (basic_tick) begin
        clk_run  <= ctrl.clk_oe;
        clk_idle <= ctrl.idle_lvl;
      end
    end
  end

  // card line sampled through two flops; the third only serves edge detection
  wire line_s    = line_sync[1];
  wire start_dn  = line_sync[2] & ~line_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) line_sync <= 3'b111;
    else line_sync <= {line_sync[1:0], line_in};
  end

  // transmitter: 10 driven bits, error check at bit 11, frame ends after bit 12
  wire tx_etu_end = basic_tick & (tx_cnt == scsif_pkg::ETU_LAST);
  wire tx_start   = (tx_st == scsif_pkg::TX_IDLE) & basic_tick & ctrl.tx_en &
                    mode.card_en & ~tx_buffer_empty;
  wire tx_last    = (tx_st == scsif_pkg::TX_FRAME) & tx_etu_end & (tx_bit == scsif_pkg::TX_END_BIT);
  wire tx_ok_ev   = tx_last & ~tx_err_seen;
  wire tx_err_ev  = tx_last & tx_err_seen;
  wire tx_chk     = (tx_st == scsif_pkg::TX_FRAME) & basic_tick & (tx_bit == scsif_pkg::TX_CHK_BIT) &
                    (tx_cnt == 9'h000);
  wire [9:0] tx_frame = {par_of(tx_data, mode.odd), tx_data, 1'b0};
  wire tx_drive   = (tx_st == scsif_pkg::TX_FRAME) & (tx_bit <= scsif_pkg::PAR_BIT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st       <= scsif_pkg::TX_IDLE;
      tx_cnt      <= 9'h000;
      tx_bit      <= 4'h0;
      tx_err_seen <= 1'b0;
    end else begin
      case (tx_st)
        scsif_pkg::TX_IDLE: begin
          tx_cnt      <= 9'h000;
          tx_bit      <= 4'h0;
          tx_err_seen <= 1'b0;
          if (tx_start) tx_st <= scsif_pkg::TX_FRAME;
        end
        scsif_pkg::TX_FRAME: begin
          if (basic_tick) tx_cnt <= tx_etu_end ? 9'h000 : tx_cnt + 9'h001;
          if (tx_etu_end) tx_bit <= tx_bit + 4'h1;
          if (tx_chk) tx_err_seen <= ~line_s;
          if (tx_err_ev) begin
            tx_bit      <= 4'h0;
            tx_err_seen <= 1'b0;
          end
          if (tx_ok_ev | ~ctrl.tx_en) tx_st <= scsif_pkg::TX_IDLE;
        end
        default: tx_st <= scsif_pkg::TX_IDLE;
      endcase
    end
  end

  // receiver: start edge restarts the tick count, bits latched mid-bit
  wire rx_sample  = (rx_st == scsif_pkg::RX_FRAME) & basic_tick & (rx_cnt == scsif_pkg::SAMPLE_AT);
  wire rx_etu_end = basic_tick & (rx_cnt == scsif_pkg::ETU_LAST);
  wire rx_false   = rx_sample & (rx_bit == 4'h0) & line_s;
  wire rx_par     = rx_sample & (rx_bit == scsif_pkg::PAR_BIT);
  wire rx_bad     = line_s != par_of(rx_shift, mode.odd);
  wire rx_perr_ev = rx_par & rx_bad;
  wire rx_good_ev = rx_par & ~rx_bad;
  wire rx_done    = rx_etu_end & (rx_bit == scsif_pkg::RX_END_BIT);
  // error signal spans the second half of bit 10 and the first half of bit 11
  wire rx_pull    = (rx_st == scsif_pkg::RX_FRAME) & rx_perr &
                    (((rx_bit == scsif_pkg::SLOT_BIT) & (rx_cnt > scsif_pkg::SAMPLE_AT)) |
                     ((rx_bit == scsif_pkg::RX_END_BIT) & (rx_cnt <= scsif_pkg::SAMPLE_AT)));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st    <= scsif_pkg::RX_IDLE;
      rx_cnt   <= 9'h000;
      rx_bit   <= 4'h0;
      rx_perr  <= 1'b0;
      rx_shift <= 8'h00;
    end else begin
      case (rx_st)
        scsif_pkg::RX_IDLE: begin
          rx_cnt  <= 9'h000;
          rx_bit  <= 4'h0;
          rx_perr <= 1'b0;
          if (start_dn & ctrl.rx_en & mode.card_en) rx_st <= scsif_pkg::RX_FRAME;
        end
        scsif_pkg::RX_FRAME: begin
          if (basic_tick) rx_cnt <= rx_etu_end ? 9'h000 : rx_cnt + 9'h001;
          if (rx_etu_end) rx_bit <= rx_bit + 4'h1;
          if (rx_sample & (rx_bit != 4'h0) & (rx_bit < scsif_pkg::PAR_BIT))
            rx_shift <= {line_s, rx_shift[7:1]};
          if (rx_perr_ev) rx_perr <= 1'b1;
          if (rx_done | rx_false | ~ctrl.rx_en) rx_st <= scsif_pkg::RX_IDLE;
        end
        default: rx_st <= scsif_pkg::RX_IDLE;
      endcase
    end
  end

  // line drive: tx frame bits, rx error pull; released otherwise
  wire next_oe  = mode.card_en & (tx_drive | rx_pull);
  wire next_out = tx_drive ? tx_frame[tx_bit] : 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_oe  <= 1'b0;
      line_out <= 1'b1;
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
    end else begin
      line_oe  <= next_oe;
      line_out <= next_out;
      sck_out  <= run_now ? ~phase : idle_now;
      sck_oe   <= mode.card_en;
    end
  end

  // status flags; every hardware set is written last so it beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_empty   <= 1'b1;
      tx_done_flag      <= 1'b1;
      rx_buffer_full    <= 1'b0;
      overrun_flag      <= 1'b0;
      parity_error_flag <= 1'b0;
      error_signal_flag <= 1'b0;
      rx_data           <= scsif_pkg::DATA_RST;
    end else begin
      if (stat_wr & ~pwdata[2]) rx_buffer_full <= 1'b0;  // write 0 clears
      if (stat_wr & ~pwdata[3]) overrun_flag <= 1'b0;
      if (stat_wr & ~pwdata[4]) parity_error_flag <= 1'b0;
      if (stat_wr & ~pwdata[5]) error_signal_flag <= 1'b0;
      if (tx_load) begin
        tx_buffer_empty <= 1'b0;
        tx_done_flag    <= 1'b0;
      end
      if (dma_rx_read) rx_buffer_full <= 1'b0;
      if (tx_ok_ev) begin
        tx_done_flag    <= 1'b1;
        tx_buffer_empty <= 1'b1;
      end
      if (tx_err_ev) error_signal_flag <= 1'b1;
      if (rx_perr_ev) begin
        parity_error_flag <= 1'b1;
        rx_data           <= rx_shift;
      end
      if (rx_good_ev & rx_buffer_full) overrun_flag <= 1'b1;
      if (rx_good_ev & ~rx_buffer_full) begin
        rx_buffer_full <= 1'b1;
        rx_data        <= rx_shift;
      end
    end
  end
  // interrupt lines; error_irq is not wired to the transfer request path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready_irq <= 1'b0;
      rx_ready_irq <= 1'b0;
      error_irq    <= 1'b0;
      dma_rx_data  <= scsif_pkg::DATA_RST;
    end else begin
      tx_ready_irq <= ctrl.tx_irq_enable & tx_done_flag;
      rx_ready_irq <= ctrl.rx_irq_enable & rx_buffer_full;
      error_irq    <= ctrl.rx_irq_enable & (overrun_flag | parity_error_flag | error_signal_flag);
      dma_rx_data  <= rx_data;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_tx_irq_rise: assert property ($rose(tx_done_flag) && ctrl.tx_irq_enable |=> tx_ready_irq)
    else $error("tx ready request missing");
  a_rx_irq_rise: assert property ($rose(rx_buffer_full) && ctrl.rx_irq_enable |=> rx_ready_irq)
    else $error("rx ready request missing");
  a_err_irq_rise: assert property (ctrl.rx_irq_enable && $rose(error_signal_flag | parity_error_flag) |=> error_irq)
    else $error("error request missing");
  a_empty_with_done: assert property (tx_done_flag |-> tx_buffer_empty)
    else $error("done flag without empty flag");
  a_load_clears_tx: assert property (tx_load && !tx_ok_ev |=> !tx_buffer_empty && !tx_done_flag)
    else $error("tx flags not cleared by data write");
  a_resend_holds_done: assert property (tx_err_ev |=> !tx_done_flag && tx_bit == 4'h0 && error_signal_flag)
    else $error("rejected frame not resent");
  a_read_clears_full: assert property (dma_rx_read && !rx_good_ev |=> !rx_buffer_full)
    else $error("rx full not cleared by read");
  a_perr_no_full: assert property (rx_perr_ev && !rx_buffer_full |=> parity_error_flag && !rx_buffer_full)
    else $error("parity error handling wrong");
  a_good_sets_full: assert property (rx_good_ev && !rx_buffer_full |=> rx_buffer_full && rx_data == $past(rx_shift))
    else $error("good frame not stored");
  a_slot_released: assert property (rx_good_ev && !tx_drive |=> !line_oe [*8])
    else $error("line driven after good frame");
  a_slot_pulled: assert property (rx_pull && mode.card_en |=> line_oe && !line_out)
    else $error("error signal not driven");
  a_sample_mid: assert property (rx_sample |-> rx_cnt == 9'h0b9)
    else $error("sample off centre");
  a_etu_wrap: assert property (tx_etu_end |=> tx_cnt == 9'h000 || tx_st == scsif_pkg::TX_IDLE)
    else $error("bit length wrong");
  a_ok_sets_done: assert property (tx_ok_ev |=> tx_done_flag ##1 (tx_ready_irq == ctrl.tx_irq_enable))
    else $error("done flag not set");
  a_no_runt: assert property (mode.fixed_clk && $past(mode.fixed_clk, 2) && $changed(sck_out)
                              |-> $past(half_wrap, 2))
    else $error("clock pulse cut short");
  c_tx_ok: cover property (tx_ok_ev);
  c_tx_resend: cover property (tx_err_ev);
  c_rx_good: cover property (rx_good_ev);
  c_rx_perr: cover property (rx_perr_ev ##[1:1000] rx_pull);
endmodule
`default_nettype wire

// >>> sim/scsif_card_model.sv
// behavioural smart card sitting on the shared open-drain data line
`timescale 1ns/1ps
`default_nettype none
module scsif_card_model #(
  parameter int BIT_CYC = 744
) (
  input  wire logic pclk,
  input  wire logic line,
  output logic      drive_low
);
  int         nack_left = 0;
  int         rx_cnt    = 0;
  logic [7:0] rx_byte;
  logic       par_ok;
  logic       err_seen  = 1'b0;
  logic       sending   = 1'b0;
  logic [8:0] bits;

  initial drive_low = 1'b0;

  // take a frame from the device; sampling mid-bit keeps clear of sync jitter
  always begin
    @(negedge line);
    if (!sending) begin
      repeat (BIT_CYC / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge pclk);
        bits[i] = line;
      end
      rx_byte = bits[7:0];
      par_ok  = ~^bits;  // even parity over data and parity bit
      repeat (BIT_CYC) @(posedge pclk);
      // reject by pulling low across the start of bit 11, where the device looks
      if (nack_left > 0) begin
        nack_left--;
        drive_low <= 1'b1;
        repeat (BIT_CYC) @(posedge pclk);
        drive_low <= 1'b0;
      end
      rx_cnt++;
    end
  end

  // send one frame as the card; bad flips parity; then watch the error slot
  task automatic send(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f        = {(^b) ^ bad, b, 1'b0};
    sending  = 1'b1;
    err_seen = 1'b0;
    for (int i = 0; i < 10; i++) begin
      drive_low <= ~f[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    drive_low <= 1'b0;
    repeat (2 * BIT_CYC) begin
      @(posedge pclk);
      if (line === 1'b0) begin
        err_seen = 1'b1;
      end
    end
    sending = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/smart_card_serial_interface_test.sv
// self-checking bench for the smart-card serial channel
`timescale 1ns/1ps
`default_nettype none
module smart_card_serial_interface_test;
  logic        pclk;
  logic        presetn      = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic [31:0] pwdata       = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dma_tx_write = 1'b0;
  logic [7:0]  dma_tx_data  = 8'h00;
  logic        dma_rx_read  = 1'b0;
  logic [7:0]  dma_rx_data;
  logic        tx_ready_irq;
  logic        rx_ready_irq;
  logic        error_irq;
  logic        line_out;
  logic        line_oe;
  logic        sck_out;
  logic        sck_oe;
  logic        card_low;
  wire logic   line_bus;
  wire logic [2:0] irqs;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          cyc             = 0;
  logic [31:0] rd;
  logic        rerr;

  // open-drain line with pull-up: either side may pull it low
  assign line_bus = (line_oe ? line_out : 1'b1) & ~card_low;
  assign irqs     = {error_irq, rx_ready_irq, tx_ready_irq};

  scsif_core u_scsif_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data), .dma_rx_read(dma_rx_read),
    .dma_rx_data(dma_rx_data), .tx_ready_irq(tx_ready_irq), .rx_ready_irq(rx_ready_irq),
    .error_irq(error_irq), .line_in(line_bus), .line_out(line_out), .line_oe(line_oe),
    .sck_out(sck_out), .sck_oe(sck_oe)
  );

  // rate 0 gives a 2-cycle basic tick, so one bit is 744 cycles
  scsif_card_model #(.BIT_CYC(744)) u_scsif_card_model (
    .pclk(pclk), .line(line_bus), .drive_low(card_low)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one apb transfer; read data and error are taken at the pready edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle transfer-controller strobe, then let the irq settle
  task automatic dma(input logic tx, input logic [7:0] d);
    @(posedge pclk);
    dma_tx_write <= tx;
    dma_rx_read  <= ~tx;
    dma_tx_data  <= d;
    @(posedge pclk);
    dma_tx_write <= 1'b0;
    dma_rx_read  <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask

  // bounded wait; the caller checks the level afterwards
  task automatic wait_irq(input int k);
    int n;
    n = 0;
    while (irqs[k] !== 1'b1 && n < 30000) begin
      @(negedge pclk);
      n++;
    end
  endtask

  task automatic t_reset();
    check("tx irq gated", tx_ready_irq, 1'b0);
    apb(scsif_pkg::ADDR_STAT, 1'b0, 32'h0);
    check("status reset", rd, 32'h3);
    apb(scsif_pkg::ADDR_RATE, 1'b0, 32'h0);
    check("rate reset", rd, {24'h0, scsif_pkg::RATE_RST});
    apb(8'h18, 1'b0, 32'h0);
    check("unmapped err", rerr, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(scsif_pkg::ADDR_RATE, 1'b1, 32'h5b);
    apb(scsif_pkg::ADDR_RATE, 1'b0, 32'h0);
    check("rate rw", rd, 32'h5b);
    apb(scsif_pkg::ADDR_RATE, 1'b1, 32'h0);
    apb(scsif_pkg::ADDR_CTRL, 1'b1, 32'h0);
    apb(scsif_pkg::ADDR_MODE, 1'b1, 32'h4);
    apb(scsif_pkg::ADDR_CTRL, 1'b1, 32'h27);
    repeat (2) @(negedge pclk);
    check("tx irq on", tx_ready_irq, 1'b1);
  endtask

  task automatic t_tx_good();
    dma(1'b1, 8'ha5);
    check("tx irq drop", tx_ready_irq, 1'b0);
    apb(scsif_pkg::ADDR_STAT, 1'b0, 32'h0);
    check("tx flags clr", rd & 32'h3, 32'h0);
    wait_irq(0);
    check("tx irq done", tx_ready_irq, 1'b1);
    check("card byte", u_scsif_card_model.rx_byte, 8'ha5);
    check("card parity", u_scsif_card_model.par_ok, 1'b1);
    apb(scsif_pkg::ADDR_STAT, 1'b0, 32'h0);
    check("tx flags set", rd & 32'h3, 32'h3);
  endtask

  task automatic t_tx_nack();
    u_scsif_card_model.nack_left = 1;
    dma(1'b1, 8'h3c);
    wait_irq(2);
    check("err irq", error_irq, 1'b1);
    check("no tx irq", tx_ready_irq, 1'b0);
    apb(scsif_pkg::ADDR_STAT, 1'b0, 32'h0);
    check("err sig flag", rd & 32'h23, 32'h20);
    apb(scsif_pkg::ADDR_STAT, 1'b1, 32'h0);
    repeat (2) @(negedge pclk);
    check("err irq clr", error_irq, 1'b0);
    wait_irq(0);
    check("resend done", tx_ready_irq, 1'b1);
    check("resend count", u_scsif_card_model.rx_cnt, 3);
    check("resend byte", u_scsif_card_model.rx_byte, 8'h3c);
  endtask

  task automatic t_rx_good();
    apb(scsif_pkg::ADDR_CTRL, 1'b1, 32'h22);
    apb(scsif_pkg::ADDR_CTRL, 1'b1, 32'h2a);
    u_scsif_card_model.send(8'h5a, 1'b0);
    check("slot released", u_scsif_card_model.err_seen, 1'b0);
    wait_irq(1);
    check("rx irq", rx_ready_irq, 1'b1);
    check("rx data", dma_rx_data, 8'h5a);
    apb(scsif_pkg::ADDR_STAT, 1'b0, 32'h0);
    check("rx flags", rd & 32'h3c, 32'h04);
    dma(1'b0, 8'h00);
    check("rx irq clr", rx_ready_irq, 1'b0);
  endtask

  task automatic t_rx_bad();
    u_scsif_card_model.send(8'h11, 1'b1);
    check("err pulse", u_scsif_card_model.err_seen, 1'b1);
    wait_irq(2);
    check("par err irq", error_irq, 1'b1);
    check("no rx irq", rx_ready_irq, 1'b0);
    apb(scsif_pkg::ADDR_STAT, 1'b0, 32'h0);
    check("par flags", rd & 32'h3c, 32'h10);
    apb(scsif_pkg::ADDR_STAT, 1'b1, 32'h0);
  endtask

  task automatic t_overrun();
    u_scsif_card_model.send(8'h21, 1'b0);
    repeat (100) @(posedge pclk);  // receiver must be idle again before the next start edge
    u_scsif_card_model.send(8'h42, 1'b0);
    wait_irq(2);
    check("ovr irq", error_irq, 1'b1);
    apb(scsif_pkg::ADDR_STAT, 1'b0, 32'h0);
    check("ovr flags", rd & 32'h3c, 32'h0c);
    check("ovr data", dma_rx_data, 8'h21);
    apb(scsif_pkg::ADDR_STAT, 1'b1, 32'h0);
  endtask

  // clock parked high, then low, then free running with a four-cycle basic period, then parked for standby
  task automatic t_fixed_clk();
    logic hi;
    logic lo;
    int   chg;
    apb(scsif_pkg::ADDR_RATE, 1'b1, 32'h1);
    apb(scsif_pkg::ADDR_MODE, 1'b1, 32'h5);
    apb(scsif_pkg::ADDR_CTRL, 1'b1, 32'h10);
    repeat (8) @(negedge pclk);
    hi = 1'b1;
    repeat (16) begin
      @(negedge pclk);
      hi = hi & sck_out;
    end
    check("clk held high", hi, 1'b1);
    apb(scsif_pkg::ADDR_CTRL, 1'b1, 32'h0);
    repeat (8) @(negedge pclk);
    lo = 1'b0;
    repeat (16) begin
      @(negedge pclk);
      lo = lo | sck_out;
    end
    check("clk held low", lo, 1'b0);
    apb(scsif_pkg::ADDR_CTRL, 1'b1, 32'h20);
    repeat (8) @(negedge pclk);
    chg = 0;
    hi  = sck_out;
    repeat (8) begin
      @(negedge pclk);
      if (sck_out !== hi) begin
        chg++;
      end
      hi = sck_out;
    end
    check("clk toggles", chg, 4);
    check("clk enabled", sck_oe, 1'b1);
    apb(scsif_pkg::ADDR_CTRL, 1'b1, 32'h10);
    repeat (8) @(posedge pclk);
    apb(scsif_pkg::ADDR_MODE, 1'b1, 32'h0);
    repeat (2) @(negedge pclk);
    check("clk parked", sck_out, 1'b1);
    check("clk released", sck_oe, 1'b0);
  endtask

  // a hang counts as a mismatch and ends the run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx_good();
    t_tx_nack();
    t_rx_good();
    t_rx_bad();
    t_overrun();
    t_fixed_clk();
    summarize();
  end
endmodule
`default_nettype wire
